// ===== asr_pkg.sv
// Shared constants, register map and types of the asynchronous serial port.
package asr_pkg;
  // Printed register offsets, kept as word indices.
  localparam logic [7:0] IDX_ICTL = 8'h0b;
  localparam logic [7:0] IDX_PFLG = 8'h0c;
  localparam logic [7:0] IDX_RSC = 8'h18;
  localparam logic [7:0] IDX_TBUF = 8'h19;
  localparam logic [7:0] IDX_RBUF = 8'h1a;
  localparam logic [7:0] IDX_PEN = 8'h8c;
  localparam logic [7:0] IDX_TSC = 8'h98;
  localparam logic [7:0] IDX_DIV = 8'h99;
  // APB byte addresses are four times the index.
  localparam logic [9:0] A_ICTL = {IDX_ICTL, 2'h0};
  localparam logic [9:0] A_PFLG = {IDX_PFLG, 2'h0};
  localparam logic [9:0] A_RSC = {IDX_RSC, 2'h0};
  localparam logic [9:0] A_TBUF = {IDX_TBUF, 2'h0};
  localparam logic [9:0] A_RBUF = {IDX_RBUF, 2'h0};
  localparam logic [9:0] A_PEN = {IDX_PEN, 2'h0};
  localparam logic [9:0] A_TSC = {IDX_TSC, 2'h0};
  localparam logic [9:0] A_DIV = {IDX_DIV, 2'h0};
  // Field positions in the receive and transmit status/control registers.
  localparam int B_PORT_EN = 7;
  localparam int B_RX_NINE = 6;
  localparam int B_SINGLE_RX = 5;
  localparam int B_CONT_RX = 4;
  localparam int B_FRAME_ERR = 2;
  localparam int B_OVERRUN = 1;
  localparam int B_RX_BIT9 = 0;
  localparam int B_CLK_SRC = 7;
  localparam int B_TX_NINE = 6;
  localparam int B_TX_ON = 5;
  localparam int B_SYNC_MODE = 4;
  localparam int B_HIGH_SPEED = 2;
  localparam int B_SHIFT_EMPTY = 1;
  localparam int B_TX_BIT9 = 0;
  // Flag, enable and global enable positions.
  localparam int B_RX_READY = 5;
  localparam int B_TX_READY = 4;
  localparam int B_GLOBAL_IE = 7;
  localparam int B_PERIPH_IE = 6;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Bit timing: sixteen ticks per bit, vote at ticks seven to nine.
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] VOTE_AT = 4'h9;
  localparam logic [1:0] PRE_LAST = 2'h3;
  localparam logic [3:0] DATA8 = 4'h8;
  localparam logic [3:0] DATA9 = 4'h9;
  localparam logic [3:0] FRAME8 = 4'ha;
  localparam logic [3:0] FRAME9 = 4'hb;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asr_rx_st_t;
endpackage

// ===== asr_baud.sv
// Baud tick generator producing sixteen ticks per bit time.
`timescale 1ns/1ns
`default_nettype none
module asr_baud
  import asr_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic run,
  input wire logic high_speed,
  input wire logic [7:0] divisor,
  // Oversample tick.
  output logic tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic [1:0] pre;
    logic tick;
  } asr_baud_st_t;
  asr_baud_st_t s_r, s_nxt;

  // Low speed divides the divisor rate by four more, giving x16 of the bit rate.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!run)
    begin
      s_nxt.cnt = RST_BYTE;
      s_nxt.pre = 2'h0;
    end
    else if (s_r.cnt == divisor)
    begin
      s_nxt.cnt = RST_BYTE;
      s_nxt.pre = s_r.pre + 2'h1;
      s_nxt.tick = high_speed || (s_r.pre == PRE_LAST);
    end
    else
      s_nxt.cnt = s_r.cnt + 8'h01;
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick;
endmodule
`default_nettype wire

// ===== asr_rx_recover.sv
// Receive data recovery: start detection and majority vote per bit.
`timescale 1ns/1ns
`default_nettype none
module asr_rx_recover
  import asr_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control and line.
  input wire logic en,
  input wire logic tick,
  input wire logic rxd,
  input wire logic nine,
  // Recovered bits.
  output logic bit_stb,
  output logic bit_val,
  output logic stop_stb
);
  typedef struct packed {
    asr_rx_st_t st;
    logic [3:0] sub;
    logic [3:0] left;
    logic [2:0] hist;
    logic bit_stb;
    logic bit_val;
    logic stop_stb;
  } asr_rec_st_t;
  asr_rec_st_t s_r, s_nxt;
  logic [2:0] win;
  logic maj;

  // The line is shifted in at x16; a bit is the majority of three samples.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.bit_stb = 1'b0;
    s_nxt.stop_stb = 1'b0;
    win = {s_r.hist[1:0], rxd};
    maj = (win[0] & win[1]) | (win[0] & win[2]) | (win[1] & win[2]);
    if (!en)
    begin
      s_nxt.st = RX_IDLE;
      s_nxt.sub = 4'h0;
    end
    else if (tick)
    begin
      s_nxt.hist = win;
      s_nxt.sub = s_r.sub + 4'h1;
      unique case (s_r.st)
        RX_IDLE:
        begin
          s_nxt.sub = 4'h1;
          if (!rxd)
            s_nxt.st = RX_START;
        end
        RX_START:
        begin
          if (s_r.sub == VOTE_AT && maj)
            s_nxt.st = RX_IDLE;
          else if (s_r.sub == SUB_LAST)
          begin
            s_nxt.st = RX_DATA;
            s_nxt.left = nine ? DATA9 : DATA8;
          end
        end
        RX_DATA:
        begin
          if (s_r.sub == VOTE_AT)
          begin
            s_nxt.bit_stb = 1'b1;
            s_nxt.bit_val = maj;
            s_nxt.left = s_r.left - 4'h1;
          end
          else if (s_r.sub == SUB_LAST && s_r.left == 4'h0)
            s_nxt.st = RX_STOP;
        end
        RX_STOP:
        begin
          if (s_r.sub == VOTE_AT)
          begin
            s_nxt.stop_stb = 1'b1;
            s_nxt.bit_val = maj;
            s_nxt.st = RX_IDLE;
          end
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign bit_stb = s_r.bit_stb;
  assign bit_val = s_r.bit_val;
  assign stop_stb = s_r.stop_stb;
endmodule
`default_nettype wire

// ===== asr_uart.sv
// Asynchronous serial port with APB registers, receive FIFO and transmitter.
// Notes on behaviour
// - Line sampled at sixteen times baud; receive shifter advances once per bit.
// - Receiver accepts frames only while continuous receive enable is set.
// - After stop bit, shift register moves into receive buffer if room.
// - Word moved into buffer sets the receive-ready flag.
// - Receive request raised only when ready flag and its enable are set.
// - Ready flag is read-only; clears when reads leave buffer empty.
// - Buffer holds two words first-in first-out; reads return them in turn.
// - Third stop bit with full buffer sets overrun and drops the word.
// - While overrun is set no word enters the receive buffer.
// - Overrun clears only by clearing continuous receive enable.
// - Low sampled stop bit sets the framing error bit.
// - Framing error and ninth bit travel with their word; reads advance both.
// - High-speed select picks the faster baud clock ratio.
// - Nine-bit select enables nine-bit reception; extra bit in ninth-bit field.
// - Setting transmit enable also sets the transmit-buffer-empty flag.
// - Nine-bit select sends the transmit ninth bit loaded before the byte.
// - Writing the transmit buffer while enabled starts a transmission.
// - Frames: start bit, eight or nine data bits, one stop, no parity.
// - Both directions shift least significant bit first.
// - Buffer-empty flag cannot be cleared by writes; loading the buffer clears it.
// - Shift register reloads only after stop bit sent; empty bit shows it.
`timescale 1ns/1ns
`default_nettype none
module asr_uart
  import asr_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [9:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins.
  input wire logic receive_pin,
  output logic transmit_pin,
  output logic transmit_pin_oe,
  // Interrupt request to the processor.
  output logic irq_request
);
  typedef struct packed {
    logic framing_error;
    logic receive_ninth_bit;
    logic [7:0] data;
  } asr_ent_t;

  typedef struct packed {
    logic [7:0] interrupt_control;
    logic [7:0] peripheral_irq_enables;
    logic serial_port_enable;
    logic receive_nine_bit_select;
    logic single_receive;
    logic continuous_receive_enable;
    logic clock_source;
    logic transmit_nine_bit_select;
    logic transmit_enable;
    logic sync_mode;
    logic high_speed_baud_select;
    logic transmit_ninth_bit;
    logic [7:0] baud_divisor;
    logic [7:0] transmit_buffer;
    logic tx_full;
    logic transmit_buffer_empty_flag;
    logic [10:0] transmit_shift_register;
    logic [3:0] tx_left;
    logic [3:0] tx_sub;
    logic tx_busy;
    logic [8:0] receive_shift_register;
    asr_ent_t [1:0] fifo;
    logic [1:0] count;
    logic rd_ptr;
    logic overrun_error;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic txd;
    logic txoe;
    logic irq;
  } asr_top_st_t;

  asr_top_st_t s_r, s_nxt;
  logic tick;
  logic bit_stb;
  logic bit_val;
  logic stop_stb;
  logic async_on;
  logic rx_on;
  logic setup;
  logic access;
  logic [7:0] rd_byte;
  logic mapped;
  asr_ent_t head;
  asr_ent_t incoming;
  logic wr_slot;
  logic receive_ready_flag;

  // Mode decode shared by the baud generator and the receiver.
  assign async_on = s_r.serial_port_enable && !s_r.sync_mode;
  assign rx_on = async_on && s_r.continuous_receive_enable;

  // Bus phase decode; pready is registered, so an access never waits.
  assign setup = psel && !penable;
  assign access = psel && penable && s_r.pready;

  // The ready flag is the buffer occupancy, so it needs no clear of its own.
  assign head = s_r.fifo[s_r.rd_ptr];
  assign receive_ready_flag = (s_r.count != 2'h0);

  // Baud ticks at x16 of the bit rate.
  asr_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .run(async_on),
    .high_speed(s_r.high_speed_baud_select),
    .divisor(s_r.baud_divisor),
    .tick(tick)
  );

  // Start detection and bit recovery from the receive pin.
  asr_rx_recover u_rec (
    .pclk(pclk),
    .presetn(presetn),
    .en(rx_on),
    .tick(tick),
    .rxd(receive_pin),
    .nine(s_r.receive_nine_bit_select),
    .bit_stb(bit_stb),
    .bit_val(bit_val),
    .stop_stb(stop_stb)
  );

  // Read mux and address decode for the register map.
  // Data is picked at the setup edge, so a pop at the access edge cannot alter it.
  always_comb
  begin
    rd_byte = RST_BYTE;
    mapped = 1'b1;
    unique case (paddr)
      A_ICTL: rd_byte = s_r.interrupt_control;
      A_PFLG:
      begin
        rd_byte[B_RX_READY] = receive_ready_flag;
        rd_byte[B_TX_READY] = s_r.transmit_buffer_empty_flag;
      end
      A_RSC:
      begin
        rd_byte[B_PORT_EN] = s_r.serial_port_enable;
        rd_byte[B_RX_NINE] = s_r.receive_nine_bit_select;
        rd_byte[B_SINGLE_RX] = s_r.single_receive;
        rd_byte[B_CONT_RX] = s_r.continuous_receive_enable;
        rd_byte[B_FRAME_ERR] = receive_ready_flag && head.framing_error;
        rd_byte[B_OVERRUN] = s_r.overrun_error;
        rd_byte[B_RX_BIT9] = receive_ready_flag && head.receive_ninth_bit;
      end
      A_TBUF: rd_byte = s_r.transmit_buffer;
      A_RBUF: rd_byte = receive_ready_flag ? head.data : RST_BYTE;
      A_PEN: rd_byte = s_r.peripheral_irq_enables;
      A_TSC:
      begin
        rd_byte[B_CLK_SRC] = s_r.clock_source;
        rd_byte[B_TX_NINE] = s_r.transmit_nine_bit_select;
        rd_byte[B_TX_ON] = s_r.transmit_enable;
        rd_byte[B_SYNC_MODE] = s_r.sync_mode;
        rd_byte[B_HIGH_SPEED] = s_r.high_speed_baud_select;
        rd_byte[B_SHIFT_EMPTY] = !s_r.tx_busy;
        rd_byte[B_TX_BIT9] = s_r.transmit_ninth_bit;
      end
      A_DIV: rd_byte = s_r.baud_divisor;
      default: mapped = 1'b0;
    endcase
  end

  // Next-state logic for the bus, registers, receive path and transmitter.
  always_comb
  begin
    s_nxt = s_r;
    incoming = '0;
    wr_slot = 1'b0;
    // Bus answers one cycle after setup; read data is captured at setup.
    s_nxt.pready = setup;
    s_nxt.pslverr = setup && !mapped;
    if (setup)
      s_nxt.prdata = {24'h000000, rd_byte};

    // Register writes and read side effects take place at the access edge.
    if (access && pwrite)
    begin
      unique case (paddr)
        A_ICTL: s_nxt.interrupt_control = pwdata[7:0];
        A_RSC:
        begin
          s_nxt.serial_port_enable = pwdata[B_PORT_EN];
          s_nxt.receive_nine_bit_select = pwdata[B_RX_NINE];
          s_nxt.single_receive = pwdata[B_SINGLE_RX];
          s_nxt.continuous_receive_enable = pwdata[B_CONT_RX];
        end
        A_TBUF:
        begin
          s_nxt.transmit_buffer = pwdata[7:0];
          s_nxt.tx_full = 1'b1;
          s_nxt.transmit_buffer_empty_flag = 1'b0;
        end
        A_PEN: s_nxt.peripheral_irq_enables = pwdata[7:0];
        A_TSC:
        begin
          s_nxt.clock_source = pwdata[B_CLK_SRC];
          s_nxt.transmit_nine_bit_select = pwdata[B_TX_NINE];
          s_nxt.transmit_enable = pwdata[B_TX_ON];
          s_nxt.sync_mode = pwdata[B_SYNC_MODE];
          s_nxt.high_speed_baud_select = pwdata[B_HIGH_SPEED];
          s_nxt.transmit_ninth_bit = pwdata[B_TX_BIT9];
          if (pwdata[B_TX_ON] && !s_r.transmit_enable)
            s_nxt.transmit_buffer_empty_flag = 1'b1;
        end
        A_DIV: s_nxt.baud_divisor = pwdata[7:0];
        default: s_nxt.pslverr = 1'b0;
      endcase
    end

    // A read of the receive buffer pops the head entry.
    if (access && !pwrite && paddr == A_RBUF && receive_ready_flag)
    begin
      s_nxt.rd_ptr = !s_r.rd_ptr;
      s_nxt.count = s_r.count - 2'h1;
    end

    // Receive shifter: one shift per recovered bit, first bit ends lowest.
    if (bit_stb)
      s_nxt.receive_shift_register = {bit_val, s_r.receive_shift_register[8:1]};

    // Stop bit: push the word with its ninth bit and framing flag.
    // A strobe still in flight when reception is switched off is dropped.
    // Fullness is judged after any pop of this cycle, so both can happen.
    if (stop_stb && rx_on)
    begin
      incoming.framing_error = !bit_val;
      if (s_r.receive_nine_bit_select)
      begin
        incoming.data = s_r.receive_shift_register[7:0];
        incoming.receive_ninth_bit = s_r.receive_shift_register[8];
      end
      else
        incoming.data = s_r.receive_shift_register[8:1];
      if (s_r.overrun_error)
        s_nxt.count = s_nxt.count;
      else if (s_nxt.count == 2'h2)
        s_nxt.overrun_error = 1'b1;
      else
      begin
        wr_slot = s_nxt.rd_ptr ^ s_nxt.count[0];
        s_nxt.fifo[wr_slot] = incoming;
        s_nxt.count = s_nxt.count + 2'h1;
      end
    end

    // Clearing continuous receive resets the receive logic and overrun.
    if (!s_r.continuous_receive_enable)
    begin
      s_nxt.overrun_error = 1'b0;
      s_nxt.receive_shift_register = 9'h000;
    end

    // Transmitter: shift one bit per sixteen ticks, least significant first.
    if (s_r.tx_busy && tick)
    begin
      s_nxt.tx_sub = s_r.tx_sub + 4'h1;
      if (s_r.tx_sub == SUB_LAST)
      begin
        s_nxt.transmit_shift_register = {1'b1, s_r.transmit_shift_register[10:1]};
        s_nxt.tx_left = s_r.tx_left - 4'h1;
        if (s_r.tx_left == 4'h1)
          s_nxt.tx_busy = 1'b0;
      end
    end

    // Reload only once the previous stop bit is out.
    // A write in the load cycle keeps the buffer full; the shifter takes the old byte.
    if (!s_nxt.tx_busy && s_r.tx_full && s_r.transmit_enable && async_on)
    begin
      s_nxt.tx_busy = 1'b1;
      s_nxt.tx_sub = 4'h0;
      s_nxt.tx_full = s_nxt.tx_full && (access && pwrite && paddr == A_TBUF);
      s_nxt.transmit_buffer_empty_flag = !s_nxt.tx_full;
      if (s_r.transmit_nine_bit_select)
      begin
        s_nxt.transmit_shift_register =
          {1'b1, s_r.transmit_ninth_bit, s_r.transmit_buffer, 1'b0};
        s_nxt.tx_left = FRAME9;
      end
      else
      begin
        s_nxt.transmit_shift_register = {2'h3, s_r.transmit_buffer, 1'b0};
        s_nxt.tx_left = FRAME8;
      end
    end

    // Clearing transmit enable aborts the frame and resets the shifter.
    // The buffer keeps its byte on abort; only the shifter is reset.
    if (!s_r.transmit_enable || !async_on)
    begin
      s_nxt.tx_busy = 1'b0;
      s_nxt.tx_sub = 4'h0;
    end

    // Pin and request outputs are registered.
    // The request is built from next-state flags so it moves with them.
    s_nxt.txd = s_nxt.tx_busy ? s_nxt.transmit_shift_register[0] : 1'b1;
    s_nxt.txoe = async_on && s_r.transmit_enable;
    s_nxt.irq = s_r.interrupt_control[B_GLOBAL_IE] && s_r.interrupt_control[B_PERIPH_IE]
      && ((s_nxt.count != 2'h0 && s_r.peripheral_irq_enables[B_RX_READY])
      || (s_nxt.transmit_buffer_empty_flag && s_r.peripheral_irq_enables[B_TX_READY]));
  end

  // State register; the transmit shifter resets empty, so its bit reads set.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.txd <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs come straight from the state register.
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign transmit_pin = s_r.txd;
  assign transmit_pin_oe = s_r.txoe;
  assign irq_request = s_r.irq;
endmodule
`default_nettype wire

// ===== asr_uart_asserts.sv
// Port-level assertions for the asynchronous serial port.
`timescale 1ns/1ns
`default_nettype none
module asr_uart_chk
  import asr_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire logic [9:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and request.
  input wire logic receive_pin,
  input wire logic transmit_pin,
  input wire logic transmit_pin_oe,
  input wire logic irq_request
);
  logic wr;
  logic mapped;
  logic oe_exp;
  logic irq_ok;
  logic tx_irq_on;
  logic [7:0] ctl_r;
  logic [7:0] pen_r;
  logic [7:0] rsc_r;
  logic [7:0] tsc_r;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Completed writes, decoded addresses and expected enables.
  assign wr = psel & penable & pready & pwrite;
  assign mapped = paddr inside {A_ICTL, A_PFLG, A_RSC, A_TBUF, A_RBUF, A_PEN, A_TSC, A_DIV};
  assign oe_exp = rsc_r[B_PORT_EN] & tsc_r[B_TX_ON] & !tsc_r[B_SYNC_MODE];
  assign irq_ok = ctl_r[B_GLOBAL_IE] & ctl_r[B_PERIPH_IE] & (pen_r[B_RX_READY] | pen_r[B_TX_READY]);
  assign tx_irq_on = ctl_r[B_GLOBAL_IE] & ctl_r[B_PERIPH_IE] & pen_r[B_TX_READY];
  // Shadow copies of the control bytes that software writes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_r <= 8'h00;
      pen_r <= 8'h00;
      rsc_r <= 8'h00;
      tsc_r <= 8'h00;
    end
    else if (wr)
    begin
      if (paddr == A_ICTL) ctl_r <= pwdata[7:0];
      if (paddr == A_PEN) pen_r <= pwdata[7:0];
      if (paddr == A_RSC) rsc_r <= pwdata[7:0];
      if (paddr == A_TSC) tsc_r <= pwdata[7:0];
    end
  end
  setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
  ready_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  bad_addr_a: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped accepted");
  good_addr_a: assert property (psel && !penable && mapped |=> !pslverr) else $error("bad slverr");
  high_bytes_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bytes");
  pin_idle_a: assert property (!transmit_pin_oe && !$past(transmit_pin_oe) |-> transmit_pin)
    else $error("pin not idle");
  pin_enable_a: assert property ($past(oe_exp) == oe_exp |-> transmit_pin_oe == oe_exp)
    else $error("enable wrong");
  irq_mask_a: assert property (irq_request |-> irq_ok || $past(irq_ok))
    else $error("request unmasked");
  tx_flag_irq_a: assert property ($rose(tsc_r[B_TX_ON]) && tx_irq_on |-> ##[1:3] irq_request)
    else $error("no empty flag");
  bit_width_a: assert property ($fell(transmit_pin) && transmit_pin_oe |-> !transmit_pin [*8])
    else $error("short bit");
endmodule
bind asr_uart asr_uart_chk i_asr_uart_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .receive_pin(receive_pin), .transmit_pin(transmit_pin), .transmit_pin_oe(transmit_pin_oe),
  .irq_request(irq_request)
);
`default_nettype wire

// ===== asr_remote.sv
// Remote serial device: sends frames to the port and decodes frames from it.
`timescale 1ns/1ns
`default_nettype none
module asr_remote #(parameter int BIT = 16)
(
  // Clock.
  input wire logic pclk,
  // Line into the port.
  output logic line,
  // Line out of the port.
  input wire logic tx_line,
  input wire logic tx_oe,
  input wire logic nine
);
  logic [8:0] got = 9'h000;
  logic stop_ok = 1'b0;
  int n_got = 0;
  initial line = 1'b1;
  // Holds one bit on the line for a whole bit time.
  task automatic drive(input logic b);
    line <= b;
    repeat (BIT) @(posedge pclk);
  endtask
  // Sends start, data least significant first, stop, then one idle bit.
  task automatic send(input logic [8:0] d, input logic nb, input logic stop);
    drive(1'b0);
    for (int i = 0; i < (nb ? 9 : 8); i++) drive(d[i]);
    drive(stop);
    drive(1'b1);
  endtask
  // Decodes each frame at the middle of every bit.
  always
  begin
    @(posedge pclk iff (tx_oe && !tx_line));
    got = 9'h000;
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < (nine ? 9 : 8); i++)
    begin
      repeat (BIT) @(posedge pclk);
      got[i] = tx_line;
    end
    repeat (BIT) @(posedge pclk);
    stop_ok = tx_line;
    n_got++;
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking testbench of the asynchronous serial port.
`timescale 1ns/1ns
`default_nettype none
module testbench
  import asr_pkg::*;
;
  logic pclk;
  logic presetn = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic nine_sel = 1'b0;
  logic irq;
  logic txoe;
  logic [7:0] rq;
  logic re;
  wire logic rxd;
  wire logic txd;
  int n_errors = 0;
  int samples_checked = 0;
  asr_uart i_asr_uart (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .receive_pin(rxd), .transmit_pin(txd), .transmit_pin_oe(txoe),
    .irq_request(irq));
  asr_remote i_asr_remote (.pclk(pclk), .line(rxd), .tx_line(txd), .tx_oe(txoe),
    .nine(nine_sel));
  // Clock at 250 MHz.
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Cuts a hung run short.
  initial
  begin
    #200000;
    n_errors++;
    finish_test();
  end
  task automatic finish_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    samples_checked++;
    if (got !== ex)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One bus transfer: setup, access until ready, then release.
  task automatic apb(input logic [9:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
      chk("pready", 8'h01, {7'h0, pready});
    rq = prdata[7:0];
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [9:0] a, input logic [7:0] ex, input string nm);
    apb(a, 1'b0, 8'h00);
    chk(nm, ex, rq);
  endtask
  task automatic wait_rx(input int n);
    for (int k = 0; k < 4000 && i_asr_remote.n_got < n; k++) @(posedge pclk);
    if (i_asr_remote.n_got < n)
      chk("frames", n[7:0], i_asr_remote.n_got[7:0]);
  endtask
  // Resets the receive logic and empties the buffer.
  task automatic drain;
    repeat (200) @(posedge pclk);
    apb(A_RSC, 1'b1, 8'h80);
    apb(A_RSC, 1'b1, 8'h90);
    repeat (3) apb(A_RBUF, 1'b0, 8'h00);
  endtask
  task automatic t_reset;
    rc(A_TSC, 8'h02, "tsc");
    rc(A_PFLG, 8'h00, "flags");
    rc(A_RSC, 8'h00, "rsc");
    rc(A_PEN, 8'h00, "pen");
    rc(A_RBUF, 8'h00, "rbuf");
    rc(A_TBUF, 8'h00, "tbuf");
    apb(10'h3fc, 1'b1, 8'h5a);
    chk("slverr", 8'h01, {7'h0, re});
    rc(10'h3fc, 8'h00, "unmapped");
    apb(A_DIV, 1'b1, 8'ha5);
    rc(A_DIV, 8'ha5, "div");
    apb(A_DIV, 1'b1, 8'h00);
    apb(A_TSC, 1'b1, 8'h04);
    apb(A_RSC, 1'b1, 8'h90);
  endtask
  task automatic t_fifo;
    apb(A_PEN, 1'b1, 8'h20);
    apb(A_ICTL, 1'b1, 8'hc0);
    i_asr_remote.send(9'h0a5, 1'b0, 1'b1);
    chk("irq", 8'h01, {7'h0, irq});
    i_asr_remote.send(9'h03c, 1'b0, 1'b1);
    apb(A_PFLG, 1'b1, 8'h00);
    rc(A_PFLG, 8'h20, "ready");
    rc(A_RBUF, 8'ha5, "first");
    rc(A_PFLG, 8'h20, "ready2");
    rc(A_RBUF, 8'h3c, "second");
    rc(A_PFLG, 8'h00, "empty");
    repeat (2) @(posedge pclk);
    chk("irq_off", 8'h00, {7'h0, irq});
    apb(A_PEN, 1'b1, 8'h00);
    i_asr_remote.send(9'h011, 1'b0, 1'b1);
    chk("irq_mask", 8'h00, {7'h0, irq});
    rc(A_RBUF, 8'h11, "third");
  endtask
  task automatic t_framing_error;
    i_asr_remote.send(9'h055, 1'b0, 1'b1);
    i_asr_remote.send(9'h0f0, 1'b0, 1'b0);
    rc(A_RSC, 8'h90, "ferr0");
    rc(A_RBUF, 8'h55, "w1");
    rc(A_RSC, 8'h94, "ferr1");
    rc(A_RBUF, 8'hf0, "w2");
    drain();
  endtask
  task automatic t_overrun;
    i_asr_remote.send(9'h001, 1'b0, 1'b1);
    i_asr_remote.send(9'h002, 1'b0, 1'b1);
    i_asr_remote.send(9'h003, 1'b0, 1'b1);
    rc(A_RSC, 8'h92, "overrun_error");
    rc(A_RBUF, 8'h01, "o1");
    rc(A_RBUF, 8'h02, "o2");
    i_asr_remote.send(9'h004, 1'b0, 1'b1);
    rc(A_PFLG, 8'h00, "blocked");
    rc(A_RSC, 8'h92, "overrun_error_kept");
    apb(A_RSC, 1'b1, 8'h80);
    apb(A_RSC, 1'b1, 8'h90);
    rc(A_RSC, 8'h90, "overrun_error_clr");
    i_asr_remote.send(9'h005, 1'b0, 1'b1);
    rc(A_RBUF, 8'h05, "o5");
  endtask
  task automatic t_nine;
    apb(A_RSC, 1'b1, 8'hd0);
    i_asr_remote.send(9'h13c, 1'b1, 1'b1);
    i_asr_remote.send(9'h0c3, 1'b1, 1'b1);
    rc(A_RSC, 8'hd1, "bit9_1");
    rc(A_RBUF, 8'h3c, "n1");
    rc(A_RSC, 8'hd0, "bit9_0");
    rc(A_RBUF, 8'hc3, "n2");
    apb(A_RSC, 1'b1, 8'h90);
  endtask
  task automatic t_off;
    logic [7:0] v[2] = '{8'h10, 8'h80};
    foreach (v[i])
    begin
      apb(A_RSC, 1'b1, v[i]);
      i_asr_remote.send(9'h077, 1'b0, 1'b1);
      rc(A_PFLG, 8'h00, "ignored");
    end
    apb(A_RSC, 1'b1, 8'h90);
  endtask
  task automatic t_tx;
    apb(A_PEN, 1'b1, 8'h10);
    apb(A_TSC, 1'b1, 8'h24);
    rc(A_PFLG, 8'h10, "tx_empty");
    apb(A_PFLG, 1'b1, 8'h00);
    rc(A_PFLG, 8'h10, "tx_keep");
    apb(A_TBUF, 1'b1, 8'h5a);
    apb(A_TBUF, 1'b1, 8'hc3);
    rc(A_PFLG, 8'h00, "tx_full");
    rc(A_TSC, 8'h24, "shift_busy");
    wait_rx(1);
    chk("tx1", 8'h5a, i_asr_remote.got[7:0]);
    wait_rx(2);
    chk("tx2", 8'hc3, i_asr_remote.got[7:0]);
    chk("stop", 8'h01, {7'h0, i_asr_remote.stop_ok});
    repeat (20) @(posedge pclk);
    rc(A_TSC, 8'h26, "shift_empty");
    nine_sel <= 1'b1;
    apb(A_TSC, 1'b1, 8'h65);
    apb(A_TBUF, 1'b1, 8'h81);
    wait_rx(3);
    chk("tx9", 8'h81, i_asr_remote.got[7:0]);
    chk("tx9_bit", 8'h01, {7'h0, i_asr_remote.got[8]});
  endtask
  // Main sequence.
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_fifo();
    t_framing_error();
    t_overrun();
    t_nine();
    t_off();
    t_tx();
    finish_test();
  end
endmodule
`default_nettype wire
